// ===== hdl/internal_param_defines.vh
// Constants for the internal parameter measurement and redundancy check block
`ifndef INTERNAL_PARAM_DEFINES_VH
`define INTERNAL_PARAM_DEFINES_VH

// Clock rate in MHz, used to turn microseconds into cycles
`define CLK_MHZ 32'd25
`define CY(us) ((us) * `CLK_MHZ)

// Register byte offsets
`define OFS_CMD 5'h00
`define OFS_CFG 5'h04
`define OFS_STACK 5'h08
`define OFS_TEMP 5'h0C
`define OFS_ASUP 5'h10
`define OFS_DSUP 5'h14
`define ADDR_W 5

// Command register fields
`define CMD_START 0
`define CMD_REDUND 1
`define STS_BUSY 0
`define STS_FAULT 1

// Configuration register fields
`define CFG_MODE_LO 0
`define CFG_MODE_HI 2
`define CFG_PS_LO 3
`define CFG_PS_HI 4
`define CFG_FORCE 5
`define CFG_RESET 8'h00

// Result range and fault code
`define RESULT_MAX 16'hDFFF
`define FAULT_BASE 16'hFF00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Entries per mode: four measurement ends then command end
`define STEPS 5
`define LAST_MEAS 3'h3
`define ENTRY_W 32

// Timing rows in microseconds, command end first, first measurement last
`define ROW_27K `CY(32'd742), `CY(32'd198), `CY(32'd151), `CY(32'd104), `CY(32'd58)
`define ROW_14K `CY(32'd858), `CY(32'd314), `CY(32'd238), `CY(32'd163), `CY(32'd87)
`define ROW_7K `CY(32'd1556), `CY(32'd547), `CY(32'd413), `CY(32'd279), `CY(32'd145)
`define ROW_3K `CY(32'd2022), `CY(32'd1012), `CY(32'd762), `CY(32'd512), `CY(32'd261)
`define ROW_2K `CY(32'd2953), `CY(32'd1943), `CY(32'd1460), `CY(32'd977), `CY(32'd494)
`define ROW_1K `CY(32'd4814), `CY(32'd3805), `CY(32'd2857), `CY(32'd1908), `CY(32'd960)
`define ROW_422 `CY(32'd8538), `CY(32'd7529), `CY(32'd5649), `CY(32'd3770), `CY(32'd1890)
`define ROW_26 `CY(32'd134211), `CY(32'd119238), `CY(32'd89431), `CY(32'd59624), `CY(32'd29818)
`define TIMES_DEFAULT {`ROW_26, `ROW_422, `ROW_1K, `ROW_2K, `ROW_3K, `ROW_7K, `ROW_14K, `ROW_27K}

`endif

// ===== hdl/internal_param_redundancy_check.v
// Internal parameter measurement sequencer with redundant filter check, AXI4-Lite slave
// Contract
// RULE1 - Measure command converts stack sum, die temperature, analog and digital supply.
// RULE2 - All eight filter modes are usable for this command.
// RULE3 - Fast mode ends measurements at 58, 104, 151, 198 us; command at 742 us.
// RULE4 - Totals are 4814 us, 8538 us and 134211 us in slow modes.
// RULE5 - Stack sum is attenuated stack voltage, sixteen bits in status group A.
// RULE6 - One stack sum count equals thirty times 100 uV.
// RULE7 - Die temperature is sixteen bits in group A, scaled by 100uV/7.6mV minus 276.
// RULE8 - Analog supply in group A, digital supply in group B, 100 uV per count.
// RULE9 - Host sets path select to 0 or 1 to get redundancy.
// RULE10 - Redundant and plain variants take identical time.
// RULE11 - Three converters own a filter machine each, plus one redundant machine.
// RULE12 - Plain internal parameter measure never applies redundancy.
// RULE13 - Bit stream feeds primary and redundant machines; compare at conversion end.
// RULE14 - Any mismatch stores fault code FF0X instead of the result.
// RULE15 - Valid results stay within 0000 to DFFF.
// RULE16 - Fault low bits flag mismatching nibbles, bit 3 for bits 15-12.
// RULE17 - Fault code low four bits are never all zero.
// RULE18 - Redundancy checks one converter path at a time.
// RULE19 - Path chosen automatically by default; host path select overrides.
// RULE20 - Force fail bit makes later redundant conversions report failure.
// RULE21 - Path select 00/01 checks converter 1; 10/11 use converters 2/3 unchecked.
// RULE22 - Order is stack sum, die temperature, analog supply, digital supply.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "internal_param_defines.vh"

module internal_param_redundancy_check #(
   parameter [8*`STEPS*`ENTRY_W-1:0] TIMES = `TIMES_DEFAULT,
   parameter ACC_W = 24,
   parameter CNT_W = 24
) (
   input wire CLOCK,
   input wire RST_N,
   input wire [2:0] MOD_BIT,
   output reg BUSY,
   input wire [`ADDR_W-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [`ADDR_W-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);

   // Sequencer states, one-hot
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // Step numbers: four measurement ends, then the command end
   localparam [2:0] STEP_STACK = 3'h0;
   localparam [2:0] STEP_TEMP = 3'h1;
   localparam [2:0] STEP_ASUP = 3'h2;
   localparam [2:0] STEP_DSUP = `LAST_MEAS;
   localparam [2:0] STEP_END = `LAST_MEAS + 3'h1;

   // Sequencer state
   reg [1:0] state_r;
   reg [CNT_W-1:0] cnt_r;
   reg [2:0] step_r;
   reg [2:0] run_mode_r;
   reg [1:0] run_ps_r;
   reg run_red_r;
   reg run_force_r;
   reg fault_seen_r;

   // Filter machines and stored results
   reg [ACC_W-1:0] acc_r [0:2];
   reg [ACC_W-1:0] red_acc_r;
   reg [15:0] stack_sum_result_r;
   reg [15:0] die_temp_result_r;
   reg [15:0] analog_supply_result_r;
   reg [15:0] digital_supply_result_r;

   // Host configuration and bus holding registers
   reg [7:0] cfg_r;
   reg aw_full_r;
   reg w_full_r;
   reg [`ADDR_W-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg start_r;
   reg start_red_r;
   integer i;

   // Clamp a filter sum into the legal result range so a fault code never looks real
   function [15:0] clamp;
      input [ACC_W-1:0] v;
      begin
         // RULE15 result range clamp
         if (v > {{(ACC_W-16){1'b0}}, `RESULT_MAX})
            clamp = `RESULT_MAX;
         else
            clamp = v[15:0];
      end
   endfunction

   // Fault code with one flag per mismatching nibble
   function [15:0] fault_code;
      input [15:0] a;
      input [15:0] b;
      begin
         // RULE14 RULE16 nibble flags
         fault_code = `FAULT_BASE | {12'h000, |(a[15:12] ^ b[15:12]), |(a[11:8] ^ b[11:8]),
            |(a[7:4] ^ b[7:4]), |(a[3:0] ^ b[3:0])};
      end
   endfunction

   // Look up a boundary time in cycles for a mode and step
   function [CNT_W-1:0] boundary;
      input [2:0] mode;
      input [2:0] step;
      integer base;
      begin
         base = (mode * `STEPS + step) * `ENTRY_W;
         boundary = TIMES[base +: CNT_W];
      end
   endfunction

   // Word address of a bus byte address; the two low bits are ignored
   function [`ADDR_W-1:0] word_addr;
      input [`ADDR_W-1:0] a;
      begin
         word_addr = {a[`ADDR_W-1:2], 2'h0};
      end
   endfunction

   // True for the offsets that hold a register, read or write alike
   function ofs_mapped;
      input [`ADDR_W-1:0] a;
      begin
         case (a)
            `OFS_CMD, `OFS_CFG, `OFS_STACK, `OFS_TEMP, `OFS_ASUP, `OFS_DSUP: ofs_mapped = 1'b1;
            default: ofs_mapped = 1'b0;
         endcase
      end
   endfunction

   // Converter index for a path select value; 00 and 01 both land on converter 1
   function [1:0] path_of;
      input [1:0] ps;
      begin
         case (ps)
            2'h2: path_of = 2'h1;
            2'h3: path_of = 2'h2;
            default: path_of = 2'h0;
         endcase
      end
   endfunction

   // One integrator step: add the modulator bit to the running sum
   function [ACC_W-1:0] integrate;
      input [ACC_W-1:0] acc;
      input bit_in;
      begin
         integrate = acc + {{(ACC_W-1){1'b0}}, bit_in};
      end
   endfunction

   // State decode shared by the sequencer, the filters and the capture
   wire running = (state_r == ST_RUN);
   wire start_now = (state_r == ST_IDLE) && start_r;
   // Converter that the current command reads
   wire [1:0] path = path_of(run_ps_r);
   // RULE9 RULE21 redundancy only on converter 1 path
   wire red_on = run_red_r & ~run_ps_r[1];
   // A boundary of the current step is reached
   wire hit = running && (cnt_r == boundary(run_mode_r, step_r));
   wire meas_end = hit && (step_r <= STEP_DSUP);
   // Primary result of the selected converter
   wire [15:0] prim_val = clamp(acc_r[path]);
   // RULE20 force fail flips a bit of the redundant result, so a mismatch follows at every checked conversion
   wire [15:0] red_val = clamp(red_acc_r) ^ {15'h0000, run_force_r};
   // RULE13 compare at end of each conversion
   wire mismatch = red_on && (prim_val != red_val);
   // RULE17 mismatch guarantees at least one nibble flag
   wire [15:0] store_val = mismatch ? fault_code(prim_val, red_val) : prim_val;

   // Sequencer; the redundant variant reuses the same timing table
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= ST_IDLE;
         cnt_r <= {CNT_W{1'b0}};
         step_r <= 3'h0;
         run_mode_r <= 3'h0;
         run_ps_r <= 2'h0;
         run_red_r <= 1'b0;
         run_force_r <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_r) begin
                  // RULE2 mode latched from configuration
                  run_mode_r <= cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
                  // RULE19 host path select overrides default converter 1
                  run_ps_r <= cfg_r[`CFG_PS_HI:`CFG_PS_LO];
                  run_force_r <= cfg_r[`CFG_FORCE];
                  // RULE12 plain command never redundant
                  run_red_r <= start_red_r;
                  cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
                  step_r <= 3'h0;
                  state_r <= ST_RUN;
                  BUSY <= 1'b1;
               end
            end
            ST_RUN: begin
               // Cycles since the command started
               cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
               if (hit) begin
                  // RULE3 RULE4 RULE10 boundaries from table
                  if (step_r == STEP_END) begin
                     state_r <= ST_IDLE;
                     BUSY <= 1'b0;
                  end
                  // Next boundary of the table
                  step_r <= step_r + 3'h1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               BUSY <= 1'b0;
            end
         endcase
      end
   end

   // Filter machines: integrate modulator ones, dump at each measurement end
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         for (i = 0; i < 3; i = i + 1)
            acc_r[i] <= {ACC_W{1'b0}};
         red_acc_r <= {ACC_W{1'b0}};
      end else begin
         // RULE11 one machine per converter
         for (i = 0; i < 3; i = i + 1) begin
            if (!running || meas_end)
               acc_r[i] <= {ACC_W{1'b0}};
            else
               acc_r[i] <= integrate(acc_r[i], MOD_BIT[i]);
         end
         // RULE13 RULE18 redundant machine follows the checked path only
         if (!running || meas_end || !red_on)
            red_acc_r <= {ACC_W{1'b0}};
         else
            red_acc_r <= integrate(red_acc_r, MOD_BIT[path]);
      end
   end

   // Result capture; stack sum first, digital supply last
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         stack_sum_result_r <= 16'h0000;
         die_temp_result_r <= 16'h0000;
         analog_supply_result_r <= 16'h0000;
         digital_supply_result_r <= 16'h0000;
         fault_seen_r <= 1'b0;
      end else begin
         // Fault flag cleared at start, set by any mismatch during the run
         if (start_now)
            fault_seen_r <= 1'b0;
         else if (meas_end && mismatch)
            fault_seen_r <= 1'b1;
         if (meas_end) begin
            // RULE1 RULE22 four quantities in order
            case (step_r)
               STEP_STACK: stack_sum_result_r <= store_val; // RULE5 RULE6 group A
               STEP_TEMP: die_temp_result_r <= store_val; // RULE7 group A
               STEP_ASUP: analog_supply_result_r <= store_val; // RULE8 group A
               STEP_DSUP: digital_supply_result_r <= store_val; // RULE8 group B
               default: digital_supply_result_r <= digital_supply_result_r;
            endcase
         end
      end
   end

   // Write channel: address and data taken in either order, answered once both are held
   wire do_write = aw_full_r && w_full_r && !S_AXI_BVALID;
   wire wr_ofs_ok = ofs_mapped(aw_addr_r);
   // Decoded request of the held write
   wire wr_cmd = (aw_addr_r == `OFS_CMD) && w_strb_r[0];
   wire wr_cfg = (aw_addr_r == `OFS_CFG) && w_strb_r[0];
   wire start_req = wr_cmd && w_data_r[`CMD_START] && (state_r == ST_IDLE);
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= {`ADDR_W{1'b0}};
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
         cfg_r <= `CFG_RESET;
         start_r <= 1'b0;
         start_red_r <= 1'b0;
      end else begin
         // Ready pulses for one cycle, only while its own channel holds nothing
         S_AXI_AWREADY <= !aw_full_r && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY <= !w_full_r && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= word_addr(S_AXI_AWADDR);
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
         end
         // Start is a one-cycle strobe to the sequencer
         start_r <= 1'b0;
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            // Unmapped offsets are refused with a slave error
            S_AXI_BRESP <= wr_ofs_ok ? `RESP_OKAY : `RESP_SLVERR;
            // Start while busy is dropped; restarting mid-run would corrupt the results
            if (start_req) begin
               start_r <= 1'b1;
               start_red_r <= w_data_r[`CMD_REDUND];
            end
            if (wr_cfg)
               cfg_r <= w_data_r[7:0];
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Read channel: one-cycle registered answer, unmapped offsets get SLVERR
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `RESP_OKAY;
      end else begin
         // No new address while an answer is still waiting
         S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RESP_OKAY;
            case (word_addr(S_AXI_ARADDR))
               `OFS_CMD: S_AXI_RDATA <= {30'h00000000, fault_seen_r, BUSY};
               `OFS_CFG: S_AXI_RDATA <= {24'h000000, cfg_r};
               `OFS_STACK: S_AXI_RDATA <= {16'h0000, stack_sum_result_r};
               `OFS_TEMP: S_AXI_RDATA <= {16'h0000, die_temp_result_r};
               `OFS_ASUP: S_AXI_RDATA <= {16'h0000, analog_supply_result_r};
               `OFS_DSUP: S_AXI_RDATA <= {16'h0000, digital_supply_result_r};
               default: begin
                  S_AXI_RDATA <= 32'h00000000;
                  S_AXI_RRESP <= `RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule // internal_param_redundancy_check

// ===== dv/ipr_props.sv
// Port assertions for the internal parameter sequencer
`timescale 1ns/10ps
`include "internal_param_defines.vh"
module ipr_props #(
   parameter [8*`STEPS*`ENTRY_W-1:0] TIMES = `TIMES_DEFAULT
) (
   input wire CLOCK,
   input wire RST_N,
   input wire BUSY,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire [31:0] S_AXI_RDATA
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // Write taken, then its response within the stated latency
   sequence wr_taken;
      S_AXI_AWREADY && S_AXI_WREADY;
   endsequence
   sequence resp_given;
      ##[1:3] S_AXI_BVALID;
   endsequence
   a_write_answer: assert property (wr_taken |-> resp_given) else $error("write not answered");
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
   a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data moved");
   a_awready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("awready too long");
   a_arready_late: assert property ($rose(S_AXI_ARVALID) |=> S_AXI_ARREADY) else $error("arready late");
   a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("rvalid late");
   a_busy_cause: assert property ($rose(BUSY) |-> $past(S_AXI_BVALID)) else $error("busy without write");
   a_busy_span: assert property ($rose(BUSY) |-> BUSY [*8]) else $error("busy too short");
   a_fault_nibble: assert property (S_AXI_RVALID && S_AXI_RDATA[15:8] == 8'hFF |-> S_AXI_RDATA[3:0] != 4'h0)
      else $error("empty fault flags");
endmodule // ipr_props
bind internal_param_redundancy_check ipr_props #(.TIMES(TIMES)) u_props (.CLOCK(CLOCK), .RST_N(RST_N),
   .BUSY(BUSY), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));

// ===== dv/mod_stream.sv
// Modulator bit streams standing in for the three converters
`timescale 1ns/10ps
module mod_stream (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic conv1_ones,
   output logic [2:0] mod_bit
);
   logic tog_r;
   // Converter 3 alternates so its count differs from the steady paths
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         tog_r <= 1'b0;
      else
         tog_r <= ~tog_r;
   end
   // Converter 1 level set by the bench, converter 2 saturated high
   assign mod_bit = {tog_r, 1'b1, conv1_ones};
endmodule // mod_stream

// ===== dv/testbench.sv
// Self-checking bench for the internal parameter sequencer
`timescale 1ns/10ps
`include "internal_param_defines.vh"
module testbench;
   // Short step times keep every mode quick: ends 8,16,24,32 plus mode, command 60 plus mode
   function automatic [8*`STEPS*`ENTRY_W-1:0] mk_times();
      integer m;
      integer k;
      begin
         mk_times = '0;
         for (m = 0; m < 8; m++)
            for (k = 0; k < 5; k++)
               mk_times[(m*5+k)*32 +: 32] = (k < 4) ? 8*(k+1)+m : 60+m;
      end
   endfunction
   localparam [8*`STEPS*`ENTRY_W-1:0] T = mk_times();
   logic clock, rst_n, conv1_ones, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata;
   wire [2:0] mod_bit;
   wire busy, awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer errors, checked, p;
   logic [31:0] d;
   logic [1:0] r;
   internal_param_redundancy_check #(.TIMES(T)) uut (.CLOCK(clock), .RST_N(rst_n), .MOD_BIT(mod_bit),
      .BUSY(busy), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   mod_stream model (.clock(clock), .rst_n(rst_n), .conv1_ones(conv1_ones), .mod_bit(mod_bit));
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("Error at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task test_done;
      $display("Checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each channel released at the edge its ready is seen
   task wr(input [4:0] a, input [31:0] v);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge clock); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge clock); while (!wready); wvalid <= 1'b0; end
      join
      do @(posedge clock); while (!bvalid);
      bready <= 1'b0;
      r = bresp;
   endtask
   task rd(input [4:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   // Start a command and measure how many edges busy stays up
   task run(input logic red, input integer m);
      integer n;
      n = 0;
      wr(`OFS_CMD, {30'h0, red, 1'b1});
      wait (busy);
      while (busy) begin
         @(posedge clock);
         #1 n++;
      end
      chk(n, 60 + m);
   endtask
   task res4(input [15:0] e, input [31:0] st);
      integer i;
      for (i = 0; i < 4; i++) begin
         rd(5'(8 + 4*i));
         chk(d, {16'h0, e});
      end
      rd(`OFS_CMD);
      chk(d, st);
   endtask
   task res_real;
      rd(`OFS_STACK);
      chk({31'h0, d != 0 && d <= 32'hDFFF}, 32'h1);
      rd(`OFS_CMD);
      chk(d, 32'h0);
   endtask
   task t_reset;
      rd(`OFS_CFG);
      chk(d, 32'h0);
      rd(5'h18);
      chk({30'h0, r}, 32'h2);
      wr(5'h18, 32'h1);
      chk({30'h0, r}, 32'h2);
   endtask
   task t_modes;
      for (p = 0; p < 8; p++) begin
         wr(`OFS_CFG, p);
         chk({30'h0, r}, 32'h0);
         rd(`OFS_CFG);
         chk(d, p);
         run(1'b0, p);
         res4(16'h0, 32'h0);
      end
   endtask
   task t_force;
      wr(`OFS_CFG, 32'h20);
      run(1'b1, 0);
      res4(16'hFF01, 32'h2);
      run(1'b0, 0);
      res4(16'h0, 32'h0);
   endtask
   task t_path;
      for (p = 2; p < 4; p++) begin
         wr(`OFS_CFG, 32'h20 | (p << 3));
         run(1'b1, 0);
         res_real();
      end
   endtask
   task t_clean;
      conv1_ones <= 1'b1;
      wr(`OFS_CFG, 32'h0);
      run(1'b1, 0);
      res_real();
      wr(`OFS_CFG, 32'h28);
      run(1'b1, 0);
      res4(16'hFF01, 32'h2);
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Whole run is under two thousand cycles
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      test_done();
   end
   initial begin
      {rst_n, conv1_ones, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, errors, checked} = '0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_force();
      t_path();
      t_clean();
      test_done();
   end
endmodule // testbench
